/* File: rtl/ata_subcommand_power_check.sv */
`timescale 1ns/1ps
// Contract
// - B0 feature selects health-monitoring subfunction
// - EF enable-type feature codes decoded
// - EF disable-type feature codes decoded
// - Device bit ignored; always device zero
// - Addressing bit: zero CHS, one LBA
// - Retry bit has no effect
// - Unused bits and don't-care digits ignored
// - Option bit used only by max-address
// - Status/error loaded at completion with interrupt
// - E5 and 98 both run power query
// - Sector count 00 standby/sleep, else FF
// - Query: BSY/DF/COR clear, only abort error
// - Fixed input bits constant, valid bits driven
module ata_subcommand_power_check (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // Command block from host
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] feature_i,
  input wire logic [7:0] sector_count_i,
  input wire logic [7:0] device_head_i,
  // Drive state
  input wire logic spun_down_i,
  input wire logic fault_i,
  // Results
  output logic [7:0] status_o,
  output logic [7:0] error_o,
  output logic [7:0] sector_count_o,
  output logic intrq_o,
  output logic lba_mode_o,
  output logic max_addr_option_o,
  // Decoded subfunctions
  output logic [3:0] health_op_o,
  output logic write_cache_o,
  output logic apm_o,
  output logic standby_powerup_o,
  output logic look_ahead_o,
  output logic revert_defaults_o,
  output logic xfer_mode_set_o,
  output logic spinup_req_o
);

  // Health subfunction code, none for unlisted values
  function automatic cmd_decode_pkg::health_op_t health_decode(
    input logic [7:0] f
  );
    unique case (f)
      cmd_decode_pkg::HM_READ_ATTR:
        return cmd_decode_pkg::OP_HM_READ_ATTR;
      cmd_decode_pkg::HM_READ_THRESH:
        return cmd_decode_pkg::OP_HM_READ_THRESH;
      cmd_decode_pkg::HM_AUTOSAVE:
        return cmd_decode_pkg::OP_HM_AUTOSAVE;
      cmd_decode_pkg::HM_SAVE_ATTR:
        return cmd_decode_pkg::OP_HM_SAVE_ATTR;
      cmd_decode_pkg::HM_OFFLINE:
        return cmd_decode_pkg::OP_HM_OFFLINE;
      cmd_decode_pkg::HM_READ_LOG:
        return cmd_decode_pkg::OP_HM_READ_LOG;
      cmd_decode_pkg::HM_WRITE_LOG:
        return cmd_decode_pkg::OP_HM_WRITE_LOG;
      cmd_decode_pkg::HM_ENABLE:
        return cmd_decode_pkg::OP_HM_ENABLE;
      cmd_decode_pkg::HM_DISABLE:
        return cmd_decode_pkg::OP_HM_DISABLE;
      cmd_decode_pkg::HM_STATUS:
        return cmd_decode_pkg::OP_HM_STATUS;
      cmd_decode_pkg::HM_AUTO_OFFLINE:
        return cmd_decode_pkg::OP_HM_AUTO_OFFLINE;
      default:
        return cmd_decode_pkg::OP_NONE;
    endcase
  endfunction : health_decode

  // Feature code known to the feature-setting command
  function automatic logic sf_known(input logic [7:0] f);
    unique case (f)
      cmd_decode_pkg::SF_WCACHE_ON,
      cmd_decode_pkg::SF_XFER_MODE,
      cmd_decode_pkg::SF_APM_ON,
      cmd_decode_pkg::SF_PUIS_ON,
      cmd_decode_pkg::SF_SPINUP,
      cmd_decode_pkg::SF_LOOKAHEAD_ON,
      cmd_decode_pkg::SF_REVERT_ON,
      cmd_decode_pkg::SF_LOOKAHEAD_OFF,
      cmd_decode_pkg::SF_REVERT_OFF,
      cmd_decode_pkg::SF_WCACHE_OFF,
      cmd_decode_pkg::SF_APM_OFF,
      cmd_decode_pkg::SF_PUIS_OFF:
        return 1'h1;
      default:
        return 1'h0;
    endcase
  endfunction : sf_known

  // Both power-query codes run the same command
  function automatic logic is_power_query(input logic [7:0] c);
    return c == cmd_decode_pkg::CMD_POWER_QUERY ||
      c == cmd_decode_pkg::CMD_POWER_QUERY_ALT;
  endfunction : is_power_query

  cmd_decode_pkg::state_t state_q, state_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] feat_q, feat_d;
  logic [7:0] status_q, status_d;
  logic [7:0] error_q, error_d;
  logic [7:0] count_q, count_d;
  logic intrq_q, intrq_d;
  logic lba_q, lba_d;
  logic opt_q, opt_d;
  cmd_decode_pkg::health_op_t hop_q, hop_d;
  logic [2:0] feat_en_q, feat_en_d;
  logic apm_q, apm_d;
  logic revert_q, revert_d;
  logic xfer_q, xfer_d;
  logic spin_q, spin_d;
  logic abort;
  logic take;
  logic exec;

  // Unknown command or subcommand aborts; full byte compares
  always_comb begin
    if (is_power_query(cmd_q)) begin
      abort = 1'h0;
    end else if (cmd_q == cmd_decode_pkg::CMD_SET_MAX_ADDR) begin
      abort = 1'h0;
    end else if (cmd_q == cmd_decode_pkg::CMD_HEALTH) begin
      abort = health_decode(feat_q) == cmd_decode_pkg::OP_NONE;
    end else if (cmd_q == cmd_decode_pkg::CMD_SET_FEATURES) begin
      abort = !sf_known(feat_q);
    end else begin
      abort = 1'h1;
    end
  end

  // Writes while busy are dropped
  assign take = cmd_write_i && state_q == cmd_decode_pkg::ST_IDLE;
  assign exec = state_q == cmd_decode_pkg::ST_EXEC;

  // Command capture and sequencing
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    feat_d = feat_q;
    lba_d = lba_q;
    opt_d = opt_q;
    unique case (state_q)
      cmd_decode_pkg::ST_IDLE: begin
        if (take) begin
          cmd_d = cmd_code_i;
          feat_d = feature_i;
          // Device-select and retry bits are never looked at
          lba_d = device_head_i[cmd_decode_pkg::LBA_BIT];
          if (cmd_code_i == cmd_decode_pkg::CMD_SET_MAX_ADDR) begin
            opt_d = sector_count_i[cmd_decode_pkg::OPTION_BIT];
          end
          state_d = cmd_decode_pkg::ST_EXEC;
        end
      end
      cmd_decode_pkg::ST_EXEC: state_d = cmd_decode_pkg::ST_DONE;
      cmd_decode_pkg::ST_DONE: state_d = cmd_decode_pkg::ST_IDLE;
      default: state_d = cmd_decode_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= cmd_decode_pkg::ST_IDLE;
      cmd_q <= 8'h00;
      feat_q <= 8'h00;
      lba_q <= 1'h0;
      opt_q <= 1'h0;
    end else if (enable_i) begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      feat_q <= feat_d;
      lba_q <= lba_d;
      opt_q <= opt_d;
    end
  end

  // Result registers
  always_comb begin
    status_d = status_q;
    error_d = error_q;
    count_d = count_q;
    intrq_d = 1'h0;
    if (take) begin
      status_d[cmd_decode_pkg::ST_BSY] = 1'h1;
    end
    if (exec) begin
      if (is_power_query(cmd_q)) begin
        count_d = spun_down_i ? cmd_decode_pkg::PWR_STANDBY
                              : cmd_decode_pkg::PWR_ACTIVE;
      end
      // Only abort may be set; other error bits fixed zero
      error_d = 8'h00;
      error_d[cmd_decode_pkg::ERR_ABORT_BIT] = abort;
      // BSY, DF, COR cleared; RDY and ERR valid
      status_d = 8'h00;
      status_d[cmd_decode_pkg::ST_RDY] = !fault_i;
      status_d[cmd_decode_pkg::ST_ERR] = abort;
      intrq_d = 1'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_q <= cmd_decode_pkg::STATUS_RESET;
      error_q <= cmd_decode_pkg::ERROR_RESET;
      count_q <= 8'h00;
      intrq_q <= 1'h0;
    end else if (enable_i) begin
      status_q <= status_d;
      error_q <= error_d;
      count_q <= count_d;
      intrq_q <= intrq_d;
    end
  end

  // Subfunction decode and feature levels
  always_comb begin
    hop_d = hop_q;
    feat_en_d = feat_en_q;
    apm_d = apm_q;
    revert_d = revert_q;
    xfer_d = 1'h0;
    spin_d = 1'h0;
    if (exec && !abort && cmd_q == cmd_decode_pkg::CMD_HEALTH) begin
      hop_d = health_decode(feat_q);
    end
    if (exec && !abort && cmd_q == cmd_decode_pkg::CMD_SET_FEATURES) begin
      unique case (feat_q)
        cmd_decode_pkg::SF_WCACHE_ON: feat_en_d[0] = 1'h1;
        cmd_decode_pkg::SF_PUIS_ON: feat_en_d[1] = 1'h1;
        cmd_decode_pkg::SF_LOOKAHEAD_ON: feat_en_d[2] = 1'h1;
        cmd_decode_pkg::SF_APM_ON: apm_d = 1'h1;
        cmd_decode_pkg::SF_REVERT_ON: revert_d = 1'h1;
        cmd_decode_pkg::SF_XFER_MODE: xfer_d = 1'h1;
        cmd_decode_pkg::SF_SPINUP: spin_d = 1'h1;
        cmd_decode_pkg::SF_WCACHE_OFF: feat_en_d[0] = 1'h0;
        cmd_decode_pkg::SF_PUIS_OFF: feat_en_d[1] = 1'h0;
        cmd_decode_pkg::SF_LOOKAHEAD_OFF: feat_en_d[2] = 1'h0;
        cmd_decode_pkg::SF_APM_OFF: apm_d = 1'h0;
        cmd_decode_pkg::SF_REVERT_OFF: revert_d = 1'h0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hop_q <= cmd_decode_pkg::OP_NONE;
      feat_en_q <= cmd_decode_pkg::FEAT_RESET;
      apm_q <= 1'h0;
      revert_q <= 1'h0;
      xfer_q <= 1'h0;
      spin_q <= 1'h0;
    end else if (enable_i) begin
      hop_q <= hop_d;
      feat_en_q <= feat_en_d;
      apm_q <= apm_d;
      revert_q <= revert_d;
      xfer_q <= xfer_d;
      spin_q <= spin_d;
    end
  end

  assign status_o = status_q;
  assign error_o = error_q;
  assign sector_count_o = count_q;
  assign intrq_o = intrq_q;
  assign lba_mode_o = lba_q;
  assign max_addr_option_o = opt_q;
  assign health_op_o = hop_q;
  assign write_cache_o = feat_en_q[0];
  assign standby_powerup_o = feat_en_q[1];
  assign look_ahead_o = feat_en_q[2];
  assign apm_o = apm_q;
  assign revert_defaults_o = revert_q;
  assign xfer_mode_set_o = xfer_q;
  assign spinup_req_o = spin_q;

endmodule : ata_subcommand_power_check

/* File: rtl/cmd_decode_pkg.sv */
package cmd_decode_pkg;

  // Command codes
  localparam logic [7:0] CMD_HEALTH = 8'hb0;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
  localparam logic [7:0] CMD_POWER_QUERY = 8'he5;
  localparam logic [7:0] CMD_POWER_QUERY_ALT = 8'h98;
  localparam logic [7:0] CMD_SET_MAX_ADDR = 8'hf9;

  // Health-monitoring subfunctions
  localparam logic [7:0] HM_READ_ATTR = 8'hd0;
  localparam logic [7:0] HM_READ_THRESH = 8'hd1;
  localparam logic [7:0] HM_AUTOSAVE = 8'hd2;
  localparam logic [7:0] HM_SAVE_ATTR = 8'hd3;
  localparam logic [7:0] HM_OFFLINE = 8'hd4;
  localparam logic [7:0] HM_READ_LOG = 8'hd5;
  localparam logic [7:0] HM_WRITE_LOG = 8'hd6;
  localparam logic [7:0] HM_ENABLE = 8'hd8;
  localparam logic [7:0] HM_DISABLE = 8'hd9;
  localparam logic [7:0] HM_STATUS = 8'hda;
  localparam logic [7:0] HM_AUTO_OFFLINE = 8'hdb;

  // Set Features subfunctions
  localparam logic [7:0] SF_WCACHE_ON = 8'h02;
  localparam logic [7:0] SF_XFER_MODE = 8'h03;
  localparam logic [7:0] SF_APM_ON = 8'h05;
  localparam logic [7:0] SF_PUIS_ON = 8'h06;
  localparam logic [7:0] SF_SPINUP = 8'h07;
  localparam logic [7:0] SF_LOOKAHEAD_ON = 8'haa;
  localparam logic [7:0] SF_REVERT_ON = 8'hcc;
  localparam logic [7:0] SF_LOOKAHEAD_OFF = 8'h55;
  localparam logic [7:0] SF_REVERT_OFF = 8'h66;
  localparam logic [7:0] SF_WCACHE_OFF = 8'h82;
  localparam logic [7:0] SF_APM_OFF = 8'h85;
  localparam logic [7:0] SF_PUIS_OFF = 8'h86;

  // Field positions
  localparam int DEV_BIT = 4;
  localparam int LBA_BIT = 6;
  localparam int OPTION_BIT = 0;
  localparam int ERR_ABORT_BIT = 2;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_ERR = 0;

  // Power-mode results and reset values
  localparam logic [7:0] PWR_STANDBY = 8'h00;
  localparam logic [7:0] PWR_ACTIVE = 8'hff;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [2:0] FEAT_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b10
  } state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_HM_READ_ATTR = 4'h1,
    OP_HM_READ_THRESH = 4'h2,
    OP_HM_AUTOSAVE = 4'h3,
    OP_HM_SAVE_ATTR = 4'h4,
    OP_HM_OFFLINE = 4'h5,
    OP_HM_READ_LOG = 4'h6,
    OP_HM_WRITE_LOG = 4'h7,
    OP_HM_ENABLE = 4'h8,
    OP_HM_DISABLE = 4'h9,
    OP_HM_STATUS = 4'ha,
    OP_HM_AUTO_OFFLINE = 4'hb
  } health_op_t;

endpackage : cmd_decode_pkg

/* File: bench/cmd_decode_checker.sv */
`timescale 1ns/1ps
module cmd_decode_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // Command block and drive state
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] feature_i,
  input wire logic [7:0] device_head_i,
  input wire logic spun_down_i,
  input wire logic fault_i,
  // Results
  input wire logic [7:0] status_o,
  input wire logic [7:0] error_o,
  input wire logic [7:0] sector_count_o,
  input wire logic intrq_o,
  input wire logic lba_mode_o,
  input wire logic max_addr_option_o,
  input wire logic [3:0] health_op_o,
  input wire logic look_ahead_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  function automatic logic [3:0] hm_op(input logic [7:0] f);
    if (f >= 8'hd0 && f <= 8'hd6) return 4'(f - 8'hcf);
    if (f >= 8'hd8 && f <= 8'hdb) return 4'(f - 8'hd0);
    return 4'h0;
  endfunction : hm_op
  sequence take_s;
    enable_i && cmd_write_i && !status_o[7];
  endsequence
  sequence query_s;
    take_s ##0 (cmd_code_i == 8'he5 || cmd_code_i == 8'h98);
  endsequence
  a_busy_after_take: assert property (take_s |=> status_o[7])
    else $error("busy not raised after command");
  a_intrq_two_later: assert property (take_s ##1 enable_i |=> intrq_o)
    else $error("completion pulse missing");
  a_query_count: assert property (query_s ##1 enable_i |=>
    sector_count_o == ($past(spun_down_i) ? 8'h00 : 8'hff))
    else $error("power mode code wrong");
  a_done_status: assert property (intrq_o |-> !status_o[7] &&
    !status_o[5] && !status_o[2] && (error_o & 8'hfb) == 8'h00)
    else $error("completion status bits wrong");
  a_ready_fault: assert property (intrq_o |-> status_o[6] == !fault_i)
    else $error("ready bit wrong");
  a_err_pair: assert property (intrq_o |-> status_o[0] == error_o[2])
    else $error("error bit and abort disagree");
  a_health_decode: assert property (take_s ##0 cmd_code_i == 8'hb0 |->
    ##2 error_o[2] == (hm_op($past(feature_i, 2)) == 4'h0) &&
    (error_o[2] || health_op_o == hm_op($past(feature_i, 2))))
    else $error("health subfunction wrong");
  a_lba_follow: assert property (take_s |->
    ##2 lba_mode_o == $past(device_head_i[6], 2))
    else $error("addressing mode wrong");
  a_option_only: assert property (take_s ##0 cmd_code_i != 8'hf9 |->
    ##1 $stable(max_addr_option_o))
    else $error("option bit changed");
  a_look_ahead: assert property (take_s ##0 cmd_code_i == 8'hef &&
    (feature_i == 8'haa || feature_i == 8'h55) |->
    ##2 look_ahead_o == ($past(feature_i, 2) == 8'haa))
    else $error("look-ahead level wrong");
endmodule : cmd_decode_checker

bind ata_subcommand_power_check cmd_decode_checker i_cmd_decode_checker (
  .clk_i, .reset_i, .enable_i, .cmd_write_i, .cmd_code_i, .feature_i,
  .device_head_i, .spun_down_i, .fault_i, .status_o, .error_o,
  .sector_count_o, .intrq_o, .lba_mode_o, .max_addr_option_o, .health_op_o,
  .look_ahead_o);

/* File: bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
  // Clock and results
  input wire logic clk_i,
  input wire logic [7:0] status_o,
  input wire logic intrq_o,
  // Command block
  output logic cmd_write_i,
  output logic [7:0] cmd_code_i,
  output logic [7:0] feature_i,
  output logic [7:0] sector_count_i,
  output logic [7:0] device_head_i
);
  initial begin
    cmd_write_i = 1'b0;
    {cmd_code_i, feature_i, sector_count_i, device_head_i} = 32'h0;
  end
  task automatic issue(input logic [7:0] code, feat, sc, dh);
    int n;
    n = 0;
    while (status_o[7] !== 1'h0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    cmd_code_i <= code;
    feature_i <= feat;
    sector_count_i <= sc;
    // Fixed ones kept set, retry bit left zero
    device_head_i <= dh | 8'ha0;
    cmd_write_i <= 1'b1;
    @(posedge clk_i);
    cmd_write_i <= 1'b0;
    do @(negedge clk_i); while (intrq_o !== 1'h1 && ++n < 60);
    @(posedge clk_i);
  endtask : issue
endmodule : host_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic enable_i = 1'b1;
  logic spun_down_i = 1'b0;
  logic fault_i = 1'b0;
  logic cmd_write_i, intrq_o, lba_mode_o, max_addr_option_o;
  logic [7:0] cmd_code_i, feature_i, sector_count_i, device_head_i;
  logic [7:0] status_o, error_o, sector_count_o;
  logic [3:0] health_op_o;
  logic write_cache_o, apm_o, standby_powerup_o, look_ahead_o;
  logic revert_defaults_o, xfer_mode_set_o, spinup_req_o;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  always #12.5 clk_i = ~clk_i;
  ata_subcommand_power_check i_ata_subcommand_power_check (.clk_i, .reset_i,
    .enable_i, .cmd_write_i, .cmd_code_i, .feature_i, .sector_count_i,
    .device_head_i, .spun_down_i, .fault_i, .status_o, .error_o,
    .sector_count_o, .intrq_o, .lba_mode_o, .max_addr_option_o, .health_op_o,
    .write_cache_o, .apm_o, .standby_powerup_o, .look_ahead_o,
    .revert_defaults_o, .xfer_mode_set_o, .spinup_req_o);
  host_model i_host_model (.clk_i, .status_o, .intrq_o, .cmd_write_i,
    .cmd_code_i, .feature_i, .sector_count_i, .device_head_i);
  task automatic check(input string name, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic run_query;
    for (int i = 0; i < 4; i++) begin
      spun_down_i <= i[0];
      i_host_model.issue(i[1] ? 8'h98 : 8'he5, 8'h00, 8'h00,
        {1'b0, i[1], 1'b0, i[0], 4'h0});
      check("count", sector_count_o, i[0] ? 8'h00 : 8'hff);
      check("status", status_o, 8'h40);
      check("error", error_o, 8'h00);
      check("lba", {7'h0, lba_mode_o}, {7'h0, i[1]});
    end
    fault_i <= 1'h1;
    i_host_model.issue(8'he5, 8'h00, 8'h00, 8'h00);
    check("fault status", status_o, 8'h00);
    fault_i <= 1'h0;
  endtask : run_query
  task automatic run_health;
    logic [7:0] f;
    logic bad;
    for (int i = 0; i < 13; i++) begin
      f = 8'hd0 + 8'(i);
      bad = (i == 7 || i == 12);
      i_host_model.issue(8'hb0, f, 8'h00, 8'h40);
      check("health error", error_o, {5'h0, bad, 2'h0});
      if (!bad) begin
        check("health op", {4'h0, health_op_o}, 8'(i < 7 ? i + 1 : i));
      end
    end
  endtask : run_health
  task automatic run_features;
    logic [7:0] code [12] = '{8'h02, 8'h05, 8'h06, 8'haa, 8'hcc, 8'h03,
      8'h07, 8'h55, 8'h66, 8'h82, 8'h85, 8'h86};
    logic [7:0] lvl [12] = '{8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f, 8'h1f,
      8'h1f, 8'h1d, 8'h1c, 8'h0c, 8'h04, 8'h00};
    for (int i = 0; i < 12; i++) begin
      i_host_model.issue(8'hef, code[i], 8'h00, 8'h00);
      check("feature levels", {3'h0, write_cache_o, apm_o, standby_powerup_o,
        look_ahead_o, revert_defaults_o}, lvl[i]);
      check("feature error", error_o, 8'h00);
      check("feature pulses", {6'h0, xfer_mode_set_o, spinup_req_o},
        {6'h0, code[i] == 8'h03, code[i] == 8'h07});
    end
  endtask : run_features
  task automatic run_misc;
    i_host_model.issue(8'h51, 8'h00, 8'h00, 8'h00);
    check("unknown status", status_o, 8'h41);
    check("unknown error", error_o, 8'h04);
    i_host_model.issue(8'hf9, 8'h00, 8'h01, 8'h40);
    check("option", {7'h0, max_addr_option_o}, 8'h01);
    i_host_model.issue(8'he5, 8'h00, 8'h00, 8'h00);
    check("option kept", {7'h0, max_addr_option_o}, 8'h01);
  endtask : run_misc
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    check("reset status", status_o, 8'h40);
    check("reset error", error_o, 8'h00);
    check("reset count", sector_count_o, 8'h00);
    reset_i <= 1'b0;
    run_query();
    run_health();
    run_features();
    run_misc();
    give_verdict();
  end
endmodule : tb_top
